// [lrp_pkg.sv]
// Purpose: shared constants for the reset, clock and power-down sequencer
// Assumes: one clock, clk at 100 MHz, standing in for the selected oscillator
// Notes: one clk cycle counts as one oscillator period
package lrp_pkg;
    localparam int unsigned LRP_CLK_HZ = 100_000_000;
    localparam int unsigned LRP_FRAME_DIV = 3072;
    localparam int unsigned LRP_RST_MIN_PERIODS = 3;
    localparam int unsigned LRP_CLEAR_CYCLES = 165;
    localparam int unsigned LRP_INIT_TIME_US = 2000;
    localparam int unsigned LRP_INIT_CYCLES = LRP_INIT_TIME_US * (LRP_CLK_HZ / 1_000_000);
    localparam int unsigned LRP_CNT_W = 20;
    localparam int unsigned LRP_VREG_W = 6;
    // nominal level in millivolts: value * 80 + 1820, value 0 means off
    localparam int unsigned LRP_MV_STEP = 80;
    localparam int unsigned LRP_MV_BASE = 1820;
    localparam int unsigned LRP_MV_W = 13;
    // reset values of the control state
    localparam logic LRP_RST_INC = 1'b1;
    localparam logic LRP_RST_SHIFT = 1'b0;
    localparam logic LRP_RST_DISP = 1'b0;
    localparam logic LRP_RST_CURS = 1'b0;
    localparam logic LRP_RST_BLINK = 1'b0;
    localparam logic LRP_RST_BUS_WIDTH = 1'b1;
    localparam logic LRP_RST_LINES = 1'b0;
    localparam logic LRP_RST_MUX = 1'b0;
    localparam logic LRP_RST_PAGE = 1'b0;
    localparam logic LRP_RST_STAGE_HI = 1'b1;
    localparam logic LRP_RST_STAGE_LO = 1'b0;
    localparam logic [5:0] LRP_RST_VREG = 6'h00;
    // control word layout
    localparam int unsigned LRP_CTL_W = 16;
    localparam int unsigned LRP_B_INC = 0;
    localparam int unsigned LRP_B_SHIFT = 1;
    localparam int unsigned LRP_B_DISP = 2;
    localparam int unsigned LRP_B_CURS = 3;
    localparam int unsigned LRP_B_BLINK = 4;
    localparam int unsigned LRP_B_BUS_WIDTH = 5;
    localparam int unsigned LRP_B_LINES = 6;
    localparam int unsigned LRP_B_MUX = 7;
    localparam int unsigned LRP_B_PAGE = 8;
    localparam int unsigned LRP_B_SYM_MODE = 9;
    localparam int unsigned LRP_B_SYM_BLINK = 10;
    localparam int unsigned LRP_B_SCREEN = 11;
    localparam int unsigned LRP_B_DCONF_P = 12;
    localparam int unsigned LRP_B_DCONF_Q = 13;
    localparam int unsigned LRP_B_TC_HI = 14;
    localparam int unsigned LRP_B_TC_LO = 15;
    localparam logic [15:0] LRP_CTL_RST = 16'h0021;
    // host register map
    localparam logic [3:0] LRP_A_CTRL = 4'h0;
    localparam logic [3:0] LRP_A_STATUS = 4'h1;
    localparam logic [3:0] LRP_A_VREG = 4'h2;
    localparam logic [3:0] LRP_A_RSTLEN = 4'h3;
    localparam int unsigned LRP_C_RESET = 0;
    localparam int unsigned LRP_C_PDOWN = 1;
    localparam int unsigned LRP_C_EXTCLK = 2;
    localparam logic [7:0] LRP_RSTLEN_DEF = 8'h04;
    typedef enum logic [1:0] {
        LRP_ST_RESET = 2'b00,
        LRP_ST_CLEAR = 2'b01,
        LRP_ST_INIT = 2'b10,
        LRP_ST_READY = 2'b11
    } lrp_state_e;
endpackage : lrp_pkg

// [lrp_if.sv]
// Purpose: pins between the sequencer device and its host
// Assumes: both ends on clk
// Notes: level signals only
`timescale 1ns/10ps
interface lrp_if;
    logic reset_pin;
    logic powerdown_pin;
    logic clk_sel_ext;
    logic busy_indicator;
    modport dev (input reset_pin, input powerdown_pin, input clk_sel_ext, output busy_indicator);
    modport host (output reset_pin, output powerdown_pin, output clk_sel_ext,
        input busy_indicator);
endinterface : lrp_if

// [lrp_device.sv]
// Purpose: reset filter, init sequence, power-down, voltage registers
// Assumes: clk is the selected clock, reset_pin synchronous to clk
// Notes: instruction decoder lies outside; it writes through instr_* ports
`timescale 1ns/10ps
// Summary of operation
// - frame tick every 3072 clocks
// - host stops clock only in power-down
// - host resets after power-up
// - reset counts only after three high periods
// - clear-display step takes 165 cycles
// - entry mode: increment, no shift
// - display, cursor, blink off
// - function set: 8-bit, one line, 1:18, page 0
// - symbol, screen, config, thermal bits cleared
// - voltage registers zero, stages hi=1 lo=0
// - busy held until 2 ms init ends
// - powerdown pin high enters power-down
// - power-down: oscillator, bias off, outputs grounded
// - power-down keeps all state except the frame counter, which it clears
// - external clock keeps instructions running
// - two 6-bit voltage registers, char and symbol
// - level equals value times 0.08 plus 1.82
// - timing independent of host bus activity
// - host ties clock input or drives clock
// - busy shown on top data line
module lrp_device
    import lrp_pkg::*;
#(
    parameter int unsigned INIT_CYCLES = lrp_pkg::LRP_INIT_CYCLES
)(
    input wire logic clk,
    input wire logic rst,
    lrp_if.dev pins,
    input wire logic instr_wr,
    input wire logic [lrp_pkg::LRP_CTL_W-1:0] instr_ctl,
    input wire logic instr_vreg_wr,
    input wire logic instr_vreg_sel,
    input wire logic [lrp_pkg::LRP_VREG_W-1:0] instr_vreg,
    input wire logic instr_stage_wr,
    input wire logic [1:0] instr_stage,
    output logic [7:0] status_byte,
    output logic [lrp_pkg::LRP_CTL_W-1:0] ctl_word,
    output logic [1:0] stage_sel,
    output logic [lrp_pkg::LRP_VREG_W-1:0] pump_level_char,
    output logic [lrp_pkg::LRP_VREG_W-1:0] pump_level_sym,
    output logic [lrp_pkg::LRP_MV_W-1:0] pump_mv,
    output logic osc_enable,
    output logic bias_enable,
    output logic drivers_grounded,
    output logic frame_tick,
    output logic clear_active
);
    import lrp_pkg::*;

    // ************************************************************
    // reset filter and sequencer
    // ************************************************************
    lrp_state_e state_r;
    lrp_state_e state_nxt;
    logic [1:0] rst_hi_r;
    logic [LRP_CNT_W-1:0] cnt_r;
    logic [11:0] frame_cnt_r;
    logic pd_r;
    logic [LRP_CTL_W-1:0] ctl_r;
    logic [1:0] stage_r;
    logic [LRP_VREG_W-1:0] va_r;
    logic [LRP_VREG_W-1:0] vb_r;
    logic busy_r;
    logic frame_r;

    // last count of a span that starts at zero
    function automatic logic lrp_span_end(input logic [LRP_CNT_W-1:0] count,
        input int unsigned span);
        lrp_span_end = (count == LRP_CNT_W'(span - 1));
    endfunction : lrp_span_end

    // a pulse must stand three edges in a row; shorter ones are ignored
    wire rst_taken = pins.reset_pin && (rst_hi_r == 2'(LRP_RST_MIN_PERIODS - 1));
    wire clear_done = lrp_span_end(cnt_r, LRP_CLEAR_CYCLES);
    wire init_done = lrp_span_end(cnt_r, INIT_CYCLES);
    // instructions run only with a clock, i.e. not in power-down unless external
    wire run = !pd_r || pins.clk_sel_ext;
    wire ready = (state_r == LRP_ST_READY);
    wire in_reset = rst || rst_taken;

    always_ff @(posedge clk)
    begin
        if (rst || !pins.reset_pin)
            rst_hi_r <= 2'h0;
        else if (rst_hi_r != 2'(LRP_RST_MIN_PERIODS - 1))
            rst_hi_r <= rst_hi_r + 2'h1;
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            LRP_ST_RESET: if (!pins.reset_pin) state_nxt = LRP_ST_CLEAR;
            LRP_ST_CLEAR: if (clear_done) state_nxt = LRP_ST_INIT;
            LRP_ST_INIT: if (init_done) state_nxt = LRP_ST_READY;
            LRP_ST_READY: state_nxt = LRP_ST_READY;
            default: state_nxt = LRP_ST_RESET;
        endcase
    end

    // a long pulse at any step restarts the sequence from the clear step
    always_ff @(posedge clk)
    begin
        if (in_reset || pins.reset_pin && state_r == LRP_ST_RESET)
            state_r <= LRP_ST_RESET;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (in_reset || state_r != state_nxt || state_r == LRP_ST_RESET)
            cnt_r <= '0;
        else if (!ready)
            cnt_r <= cnt_r + LRP_CNT_W'(1);
    end

    // busy also covers the clear step and a pulse once taken on its third edge
    always_ff @(posedge clk)
    begin
        busy_r <= in_reset || !(state_nxt == LRP_ST_READY);
    end

    // ************************************************************
    // control state: reset values, instruction writes
    // ************************************************************
    // writes wait for ready, and for a running clock in power-down
    always_ff @(posedge clk)
    begin
        if (in_reset)
        begin
            ctl_r <= LRP_CTL_RST;
            stage_r <= {LRP_RST_STAGE_HI, LRP_RST_STAGE_LO};
            va_r <= LRP_RST_VREG;
            vb_r <= LRP_RST_VREG;
        end
        else if (ready && run)
        begin
            if (instr_wr)
                ctl_r <= instr_ctl;
            if (instr_stage_wr)
                stage_r <= instr_stage;
            if (instr_vreg_wr && !instr_vreg_sel)
                va_r <= instr_vreg;
            if (instr_vreg_wr && instr_vreg_sel)
                vb_r <= instr_vreg;
        end
    end

    // ************************************************************
    // power-down and frame timing
    // ************************************************************
    // the pin is taken one edge late; the power-down outputs follow this register
    always_ff @(posedge clk)
    begin
        if (rst)
            pd_r <= 1'b0;
        else
            pd_r <= pins.powerdown_pin;
    end

    // frame timing runs free of host traffic
    wire frame_wrap = (frame_cnt_r == 12'(LRP_FRAME_DIV - 1));

    always_ff @(posedge clk)
    begin
        if (rst || pd_r)
        begin
            frame_cnt_r <= 12'h000;
            frame_r <= 1'b0;
        end
        else
        begin
            frame_r <= frame_wrap;
            if (frame_wrap)
                frame_cnt_r <= 12'h000;
            else
                frame_cnt_r <= frame_cnt_r + 12'h001;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    wire [LRP_VREG_W-1:0] vsel = ctl_r[LRP_B_SYM_MODE] ? vb_r : va_r;
    wire vsel_off = (vsel == 6'h00);
    // a zero level means the generator is off, so no bias either
    wire [LRP_MV_W-1:0] mv = vsel_off ? '0 :
        LRP_MV_W'(vsel * LRP_MV_STEP + LRP_MV_BASE);

    assign pins.busy_indicator = busy_r;
    assign status_byte = {busy_r, 7'h00};
    assign ctl_word = ctl_r;
    assign stage_sel = stage_r;
    assign pump_level_char = va_r;
    assign pump_level_sym = vb_r;
    assign pump_mv = pd_r ? '0 : mv;
    assign osc_enable = !pd_r;
    assign bias_enable = !pd_r && !vsel_off;
    assign drivers_grounded = pd_r;
    assign frame_tick = frame_r;
    assign clear_active = (state_r == LRP_ST_CLEAR);
endmodule : lrp_device

// [lrp_host.sv]
// Purpose: host end: drives reset, power-down and clock select from registers
// Assumes: software port with read data one cycle after the read strobe
// Notes: reset pulse length is a register, at least three clocks
`timescale 1ns/10ps
module lrp_host
    import lrp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    lrp_if.host pins,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    import lrp_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] rstlen_r;
    logic [7:0] rst_cnt_r;
    logic pd_r;
    logic ext_r;
    logic [7:0] rdata_r;
    logic por_done_r;

    wire wr_ctrl = wr && (addr == LRP_A_CTRL);
    wire wr_len = wr && (addr == LRP_A_RSTLEN);
    wire start_rst = !por_done_r || (wr_ctrl && wdata[LRP_C_RESET]);
    wire [7:0] len_min = (wdata < 8'(LRP_RST_MIN_PERIODS)) ? 8'(LRP_RST_MIN_PERIODS) : wdata;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rstlen_r <= LRP_RSTLEN_DEF;
            pd_r <= 1'b0;
            ext_r <= 1'b0;
            por_done_r <= 1'b0;
        end
        else
        begin
            por_done_r <= 1'b1;
            if (wr_len)
                rstlen_r <= len_min;
            if (wr_ctrl)
            begin
                pd_r <= wdata[LRP_C_PDOWN];
                ext_r <= wdata[LRP_C_EXTCLK];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rst_cnt_r <= 8'h00;
        else if (start_rst)
            rst_cnt_r <= rstlen_r;
        else if (rst_cnt_r != 8'h00)
            rst_cnt_r <= rst_cnt_r - 8'h01;
    end

    wire [7:0] rd_mux = (addr == LRP_A_CTRL) ?
            {5'h00, ext_r, pd_r, pins.reset_pin} :
        (addr == LRP_A_STATUS) ? {pins.busy_indicator, 7'h00} :
        (addr == LRP_A_RSTLEN) ? rstlen_r : 8'h00;

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else
            rdata_r <= rd ? rd_mux : 8'h00;
    end

    assign pins.reset_pin = (rst_cnt_r != 8'h00);
    assign pins.powerdown_pin = pd_r;
    assign pins.clk_sel_ext = ext_r;
    assign rdata = rdata_r;
endmodule : lrp_host

// [lrp_chk_sva.sv]
// Purpose: checks on the pins and outputs of the sequencer
// Assumes: one clock, rst synchronous active high
// Notes: counters measure the long spans
`timescale 1ns/10ps
module lrp_chk_sva
    import lrp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic powerdown_pin,
    input wire logic clk_sel_ext,
    input wire logic busy_indicator,
    input wire logic clear_active,
    input wire logic osc_enable,
    input wire logic bias_enable,
    input wire logic drivers_grounded,
    input wire logic frame_tick,
    input wire logic [lrp_pkg::LRP_CTL_W-1:0] ctl_word,
    input wire logic [1:0] stage_sel,
    input wire logic [lrp_pkg::LRP_VREG_W-1:0] pump_level_char,
    input wire logic [lrp_pkg::LRP_VREG_W-1:0] pump_level_sym,
    input wire logic [7:0] status_byte
);
    // ************
    // checks
    // ************
    logic [8:0] clr_cnt_r;
    logic [12:0] gap_r;
    logic seen_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // tick spacing is only trusted once running freely and idle
    always_ff @(posedge clk)
    begin
        clr_cnt_r <= (clear_active && !rst) ? clr_cnt_r + 9'h001 : 9'h000;
        gap_r <= frame_tick ? 13'h0000 : gap_r + 13'h0001;
        seen_r <= !(rst || busy_indicator || !osc_enable) && (seen_r || frame_tick);
    end
    sequence long_pulse;
        reset_pin [*3];
    endsequence
    sequence release_s;
        long_pulse ##1 !reset_pin;
    endsequence
    chk_busy_start: assert property ($fell(rst) |-> busy_indicator)
        else $error("busy low after reset");
    chk_reset_state: assert property ($fell(rst) |-> ctl_word == 16'h0021 &&
        stage_sel == 2'b10 && pump_level_char == 6'h00 && pump_level_sym == 6'h00)
        else $error("state after reset wrong");
    chk_clear_len: assert property ($fell(clear_active) && !reset_pin && !$past(rst) |->
        clr_cnt_r == 9'h0A5)
        else $error("clear step length wrong");
    chk_busy_clear: assert property (clear_active |-> busy_indicator)
        else $error("idle during clear");
    chk_pulse_taken: assert property (long_pulse |=> busy_indicator && !clear_active)
        else $error("long reset pulse not held");
    chk_init_start: assert property (release_s |-> ##[1:2] clear_active)
        else $error("init did not start");
    chk_pd_enter: assert property (powerdown_pin |=>
        !osc_enable && !bias_enable && drivers_grounded)
        else $error("power-down outputs wrong");
    chk_pd_exit: assert property (!powerdown_pin |=> osc_enable && !drivers_grounded)
        else $error("outputs grounded while running");
    chk_pd_frozen: assert property (powerdown_pin && $past(powerdown_pin) && !clk_sel_ext &&
        !$past(clk_sel_ext) |=> $stable(ctl_word) && $stable(stage_sel))
        else $error("state changed in power-down");
    chk_frame_gap: assert property (frame_tick && seen_r |-> gap_r == 13'h0BFF)
        else $error("frame tick spacing wrong");
    chk_status_busy: assert property (status_byte == {busy_indicator, 7'h00})
        else $error("status byte wrong");
endmodule : lrp_chk_sva

// [testbench.sv]
// Purpose: self-checking bench for host and device ends
// Assumes: INIT_CYCLES cut to 20
// Notes: host register port drives the reset, power-down and clock select pins
`timescale 1ns/10ps
module testbench;
    import lrp_pkg::*;
    // ************
    // bench
    // ************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic instr_wr = 1'b0;
    logic [15:0] instr_ctl = 16'h0000;
    logic instr_vreg_wr = 1'b0;
    logic instr_vreg_sel = 1'b0;
    logic [5:0] instr_vreg = 6'h00;
    logic instr_stage_wr = 1'b0;
    logic [1:0] instr_stage = 2'h0;
    logic [7:0] status_byte;
    logic [15:0] ctl_word;
    logic [1:0] stage_sel;
    logic [5:0] pump_level_char;
    logic [5:0] pump_level_sym;
    logic [12:0] pump_mv;
    logic osc_enable, bias_enable, drivers_grounded, frame_tick, clear_active;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    lrp_if bus_if();
    always #5 clk = ~clk;
    lrp_host i_lrp_host (.clk(clk), .rst(rst), .pins(bus_if), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    lrp_device #(.INIT_CYCLES(20)) i_lrp_device (.clk(clk), .rst(rst), .pins(bus_if),
        .instr_wr(instr_wr), .instr_ctl(instr_ctl), .instr_vreg_wr(instr_vreg_wr),
        .instr_vreg_sel(instr_vreg_sel), .instr_vreg(instr_vreg),
        .instr_stage_wr(instr_stage_wr), .instr_stage(instr_stage),
        .status_byte(status_byte), .ctl_word(ctl_word), .stage_sel(stage_sel),
        .pump_level_char(pump_level_char), .pump_level_sym(pump_level_sym),
        .pump_mv(pump_mv), .osc_enable(osc_enable), .bias_enable(bias_enable),
        .drivers_grounded(drivers_grounded), .frame_tick(frame_tick),
        .clear_active(clear_active));
    lrp_chk_sva i_lrp_chk_sva (.clk(clk), .rst(rst), .reset_pin(bus_if.reset_pin),
        .powerdown_pin(bus_if.powerdown_pin), .clk_sel_ext(bus_if.clk_sel_ext),
        .busy_indicator(bus_if.busy_indicator), .clear_active(clear_active),
        .osc_enable(osc_enable), .bias_enable(bias_enable),
        .drivers_grounded(drivers_grounded), .frame_tick(frame_tick), .ctl_word(ctl_word),
        .stage_sel(stage_sel), .pump_level_char(pump_level_char),
        .pump_level_sym(pump_level_sym), .status_byte(status_byte));
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : sw_wr
    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : sw_rd
    // k: 0 control word, 1 char level, 2 symbol level, 3 stages
    task automatic ins(input int k, input logic [15:0] v);
        @(posedge clk);
        instr_ctl <= v;
        instr_vreg <= v[5:0];
        instr_vreg_sel <= (k == 2);
        instr_stage <= v[1:0];
        instr_wr <= (k == 0);
        instr_vreg_wr <= (k == 1 || k == 2);
        instr_stage_wr <= (k == 3);
        @(posedge clk);
        {instr_wr, instr_vreg_wr, instr_stage_wr} <= 3'h0;
        #1;
    endtask : ins
    task automatic wait_ready(output int n);
        n = 0;
        while (bus_if.busy_indicator !== 1'b0 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask : wait_ready
    task automatic t_reset();
        int n;
        logic [7:0] d;
        chk(bus_if.busy_indicator === 1'b1 && status_byte === 8'h80, "not busy");
        sw_rd(LRP_A_STATUS, d);
        chk(d === 8'h80, "status not busy");
        ins(0, 16'h0004);
        wait_ready(n);
        chk(n > 160 && n < 400, "init length");
        chk(ctl_word === 16'h0021, "control word after init");
        chk({stage_sel, pump_level_char, pump_level_sym, pump_mv} === 27'h400_0000, "pump");
        sw_rd(LRP_A_STATUS, d);
        chk(d === 8'h00, "status still busy");
        chk(status_byte === 8'h00, "status byte still busy");
    endtask : t_reset
    task automatic t_pump();
        ins(1, 16'h000A);
        chk(pump_level_char === 6'h0A && pump_mv === 13'h0A3C, "char level");
        ins(2, 16'h003F);
        chk(pump_level_sym === 6'h3F && pump_level_char === 6'h0A, "symbol level");
        ins(0, 16'h0200);
        chk(pump_mv === 13'h1ACC, "symbol mode level");
        ins(3, 16'h0001);
        chk(stage_sel === 2'b01, "stage select");
    endtask : t_pump
    task automatic t_pd();
        logic [7:0] d;
        sw_wr(LRP_A_CTRL, 8'h02);
        repeat (3) @(posedge clk);
        #1 chk({osc_enable, bias_enable, drivers_grounded} === 3'b001, "pd outputs");
        ins(0, 16'h0004);
        chk(ctl_word === 16'h0200, "state changed in pd");
        sw_wr(LRP_A_CTRL, 8'h06);
        ins(0, 16'h0004);
        chk(ctl_word === 16'h0004, "ext clock instr lost");
        sw_rd(LRP_A_CTRL, d);
        chk(d === 8'h06, "control readback");
        sw_wr(LRP_A_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk(osc_enable === 1'b1 && bias_enable === 1'b1 && drivers_grounded === 1'b0,
            "pd exit");
    endtask : t_pd
    task automatic t_frame();
        int n;
        n = 0;
        repeat (6144)
        begin
            @(posedge clk);
            #1 if (frame_tick === 1'b1) n++;
        end
        chk(n == 2, "frame tick count");
    endtask : t_frame
    task automatic t_hostreset();
        int n;
        logic [7:0] d;
        sw_wr(LRP_A_RSTLEN, 8'h01);
        sw_wr(LRP_A_CTRL, 8'h01);
        repeat (6) @(posedge clk);
        #1 chk(bus_if.busy_indicator === 1'b1, "reset pulse ignored");
        wait_ready(n);
        chk(n < 1000, "busy stuck after reset pulse");
        chk(ctl_word === 16'h0021 && pump_level_char === 6'h00 &&
            pump_level_sym === 6'h00 && stage_sel === 2'b10, "no reinit");
        sw_rd(4'hF, d);
        chk(d === 8'h00, "unmapped read");
    endtask : t_hostreset
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pump();
        t_pd();
        t_frame();
        t_hostreset();
        results();
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            results();
        end
    end
endmodule : testbench
